// file: rtl/sdc_buf.sv
`timescale 1ns/10ps
module sdc_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (AW+1)'(D));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_idx];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
    bump = (idx == AW'(D - 1)) ? '0 : AW'(idx + 1'b1);
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_idx <= bump(wr_idx);
      end
      if (pop) begin
        rd_idx <= bump(rd_idx);
      end
      if (push & ~pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop & ~push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < D; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end
endmodule

// file: rtl/sdc_crc.sv
`timescale 1ns/10ps
module sdc_crc import sdc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  input wire sdc_word_t poly_i,
  // result
  output sdc_word_t crc_o
);
  // msb-first serial division, one bit per sample event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= `SDC_RST_WORD;
    end else if (clear_i) begin
      crc_o <= `SDC_RST_WORD;
    end else if (bit_valid_i) begin
      crc_o <= {crc_o[`SDC_WORD_W-2:0], 1'b0} ^ ((crc_o[`SDC_WORD_W-1] ^ bit_i) ? poly_i : `SDC_RST_WORD);
    end
  end
endmodule

// file: rtl/sdc_params.svh
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
// frame and checksum width
`define SDC_WORD_W 8
// transmit and receive buffer depth
`define SDC_BUF_DEPTH 2
// system clock and master serial clock, in ns
`define SDC_CLK_PERIOD_NS 10
`define SDC_SCK_PERIOD_NS 80
// system clocks per half serial clock period
`define SDC_HALF_CYC ((`SDC_SCK_PERIOD_NS / `SDC_CLK_PERIOD_NS) / 2)
// last bit index of a frame
`define SDC_LAST_BIT 3'h7
// reset values
`define SDC_RST_WORD 8'h00
`endif

// file: rtl/sdc_pkg.sv
package sdc_pkg;
`include "sdc_params.svh"
  typedef logic [`SDC_WORD_W-1:0] sdc_word_t;
  typedef enum logic {SDC_IDLE, SDC_SHIFT} sdc_state_t;
endpackage

// file: rtl/sdc_top.sv
`timescale 1ns/10ps
module sdc_top import sdc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control register a access
  input wire logic ctl_write_i,
  input wire logic peripheral_enable_i,
  input wire logic master_select_i,
  output logic peripheral_enable_o,
  output logic master_select_o,
  // configuration levels
  input wire logic soft_select_mode_i,
  input wire logic soft_select_level_i,
  input wire logic select_output_enable_i,
  input wire logic rx_only_i,
  input wire logic tx_only_i,
  input wire logic ti_mode_i,
  input wire logic checksum_enable_i,
  input wire logic checksum_next_i,
  input wire sdc_word_t poly_i,
  input wire logic tx_dma_enable_i,
  input wire logic rx_dma_enable_i,
  input wire logic dma_last_i,
  // interrupt enables
  input wire logic tx_empty_irq_enable_i,
  input wire logic rx_full_irq_enable_i,
  input wire logic error_irq_enable_i,
  // status access and flag clears
  input wire logic stat_access_i,
  input wire logic checksum_error_clear_i,
  input wire logic format_error_clear_i,
  // transmit data
  input wire sdc_word_t tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // receive data
  output sdc_word_t rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // status flags
  output logic tx_empty_flag_o,
  output logic rx_full_flag_o,
  output logic shift_active_flag_o,
  output logic config_fault_flag_o,
  output logic rx_overrun_flag_o,
  output logic checksum_error_flag_o,
  output logic format_error_flag_o,
  output sdc_word_t tx_checksum_o,
  output sdc_word_t rx_checksum_o,
  // dma and interrupt
  output logic tx_dma_req_o,
  output logic rx_dma_req_o,
  output logic irq_o,
  // serial pins, enables active low
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic nss_i,
  output logic nss_o,
  output logic nss_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sck_q;
  logic [2:0] nss_q;
  logic [1:0] mosi_q;
  logic [1:0] miso_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 3'h0;
      nss_q <= 3'h7;
      mosi_q <= 2'h0;
      miso_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], sck_i};
      nss_q <= {nss_q[1:0], nss_i};
      mosi_q <= {mosi_q[0], mosi_i};
      miso_q <= {miso_q[0], miso_i};
    end
  end

  // ----------------------------------------------------------------
  // shared state and events
  // ----------------------------------------------------------------
  sdc_state_t state;
  logic en;
  logic mst;
  logic m_sck;
  logic [3:0] div_cnt;
  logic [2:0] bit_cnt;
  logic got_all;
  logic crc_frame;
  logic crc_pending;
  sdc_word_t shift_out;
  sdc_word_t shift_in;
  logic config_fault;
  logic fault_armed;
  logic overrun;
  logic overrun_armed;
  logic crc_err;
  logic fmt_err;
  sdc_word_t tx_word;
  logic tx_avail;
  logic rx_buf_ready;

  logic nss_low;
  logic nss_edge;
  logic s_rise;
  logic s_fall;
  logic m_tick;
  logic ev_sample;
  logic ev_shift;
  logic din;
  logic finish;
  logic slave_go;
  logic master_go;
  logic cont;
  logic load;
  logic load_crc;
  logic tx_pop;
  logic rx_push;
  logic fault_now;

  assign nss_low = ~nss_q[1];
  assign nss_edge = nss_q[1] ^ nss_q[2];
  assign s_rise = ~mst & (state == SDC_SHIFT) & sck_q[1] & ~sck_q[2];
  assign s_fall = ~mst & (state == SDC_SHIFT) & ~sck_q[1] & sck_q[2];
  assign m_tick = mst & (state == SDC_SHIFT) & (div_cnt == 4'(`SDC_HALF_CYC - 1));
  assign ev_sample = mst ? (m_tick & ~m_sck) : s_rise;
  assign ev_shift = mst ? (m_tick & m_sck) : s_fall;
  assign din = mst ? miso_q[1] : mosi_q[1];
  assign finish = ev_shift & got_all;

  // slave frames run while selected, TI frames on the clock alone
  assign slave_go = ~mst & en & (ti_mode_i | nss_low);
  assign master_go = mst & en & (tx_avail | rx_only_i | crc_pending);
  assign cont = mst ? master_go : slave_go;
  assign load = ((state == SDC_IDLE) & (mst ? master_go : slave_go)) | (finish & cont);

  // receive-only sends its checksum frame right after the last data frame
  assign load_crc = load & crc_pending & (rx_only_i ? finish : ~tx_avail);
  assign tx_pop = load & ~load_crc & ~rx_only_i & tx_avail;
  assign rx_push = finish & ~crc_frame & ~tx_only_i & rx_buf_ready;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  sdc_buf #(.W(`SDC_WORD_W), .D(`SDC_BUF_DEPTH)) u_tx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(tx_word),
    .out_valid_o(tx_avail),
    .out_ready_i(tx_pop)
  );

  sdc_buf #(.W(`SDC_WORD_W), .D(`SDC_BUF_DEPTH)) u_rx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(shift_in),
    .in_valid_i(rx_push),
    .in_ready_o(rx_buf_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // ----------------------------------------------------------------
  // checksum calculators
  // ----------------------------------------------------------------
  // checksum frames are kept out of the sums so the received one can be compared directly
  sdc_crc u_tx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~checksum_enable_i),
    .bit_valid_i(ev_sample & ~crc_frame),
    .bit_i(shift_out[`SDC_WORD_W-1]),
    .poly_i(poly_i),
    .crc_o(tx_checksum_o)
  );

  sdc_crc u_rx_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~checksum_enable_i),
    .bit_valid_i(ev_sample & ~crc_frame),
    .bit_i(din),
    .poly_i(poly_i),
    .crc_o(rx_checksum_o)
  );

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SDC_IDLE;
    end else if (load) begin
      state <= SDC_SHIFT;
    end else begin
      case (state)
        SDC_IDLE: state <= SDC_IDLE;
        SDC_SHIFT: begin
          // outside TI mode, a deselected slave drops a partial frame
          if (finish | (~mst & ~ti_mode_i & ~nss_low)) begin
            state <= SDC_IDLE;
          end
        end
        default: state <= SDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
      m_sck <= 1'b0;
    end else if (~mst | (state != SDC_SHIFT) | load) begin
      div_cnt <= 4'h0;
      m_sck <= 1'b0;
    end else if (m_tick) begin
      div_cnt <= 4'h0;
      m_sck <= ~m_sck;
    end else begin
      div_cnt <= 4'(div_cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= 3'h0;
      got_all <= 1'b0;
    end else if (load | (state == SDC_IDLE)) begin
      bit_cnt <= 3'h0;
      got_all <= 1'b0;
    end else if (ev_sample) begin
      bit_cnt <= 3'(bit_cnt + 1'b1);
      got_all <= (bit_cnt == `SDC_LAST_BIT);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_out <= `SDC_RST_WORD;
      shift_in <= `SDC_RST_WORD;
      crc_frame <= 1'b0;
    end else begin
      if (load) begin
        // an empty buffer sends zeros
        shift_out <= load_crc ? tx_checksum_o : (tx_pop ? tx_word : `SDC_RST_WORD);
        crc_frame <= load_crc;
      end else if (ev_shift) begin
        shift_out <= {shift_out[`SDC_WORD_W-2:0], 1'b0};
      end
      if (ev_sample) begin
        shift_in <= {shift_in[`SDC_WORD_W-2:0], din};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_pending <= 1'b0;
    end else if (~checksum_enable_i | load_crc) begin
      crc_pending <= 1'b0;
    end else if (checksum_next_i | (dma_last_i & (tx_dma_enable_i | rx_dma_enable_i))) begin
      crc_pending <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control bits and configuration fault
  // ----------------------------------------------------------------
  assign fault_now = mst & (soft_select_mode_i ? ~soft_select_level_i : (~select_output_enable_i & nss_low));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en <= 1'b0;
      mst <= 1'b0;
    end else if (fault_now) begin
      en <= 1'b0;
      mst <= 1'b0;
    end else if (ctl_write_i & ~config_fault) begin
      en <= peripheral_enable_i;
      mst <= master_select_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      config_fault <= 1'b0;
      fault_armed <= 1'b0;
    end else if (fault_now) begin
      config_fault <= 1'b1;
      fault_armed <= 1'b0;
    end else if (config_fault & fault_armed & ctl_write_i) begin
      config_fault <= 1'b0;
      fault_armed <= 1'b0;
    end else if (config_fault & stat_access_i) begin
      fault_armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // receive errors
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
      overrun_armed <= 1'b0;
    end else if (finish & ~crc_frame & ~tx_only_i & ~rx_buf_ready) begin
      overrun <= 1'b1;
      overrun_armed <= 1'b0;
    end else if (overrun & overrun_armed & stat_access_i) begin
      overrun <= 1'b0;
      overrun_armed <= 1'b0;
    end else if (overrun & rx_valid_o & rx_ready_i) begin
      overrun_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_err <= 1'b0;
    end else if (finish & crc_frame & checksum_enable_i & (shift_in != rx_checksum_o)) begin
      crc_err <= 1'b1;
    end else if (checksum_error_clear_i) begin
      crc_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fmt_err <= 1'b0;
    end else if (~mst & en & ti_mode_i & nss_edge & (state == SDC_SHIFT) & (bit_cnt != 3'h0)) begin
      fmt_err <= 1'b1;
    end else if (format_error_clear_i) begin
      fmt_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign peripheral_enable_o = en;
  assign master_select_o = mst;
  assign tx_empty_flag_o = ~tx_avail;
  assign rx_full_flag_o = rx_valid_o;
  assign shift_active_flag_o = (state == SDC_SHIFT);
  assign config_fault_flag_o = config_fault;
  assign rx_overrun_flag_o = overrun;
  assign checksum_error_flag_o = crc_err;
  assign format_error_flag_o = fmt_err;
  assign tx_dma_req_o = tx_dma_enable_i & ~tx_avail;
  assign rx_dma_req_o = rx_dma_enable_i & rx_valid_o;

  // shift activity is deliberately absent from the interrupt
  assign irq_o = (tx_empty_irq_enable_i & ~tx_avail) | (rx_full_irq_enable_i & rx_valid_o) |
                 (error_irq_enable_i & (config_fault | overrun | crc_err | fmt_err));

  assign sck_o = m_sck;
  assign sck_oe_n_o = ~(mst & en);
  assign nss_o = 1'b0;
  assign nss_oe_n_o = ~(mst & en & select_output_enable_i & ~soft_select_mode_i);
  assign mosi_o = shift_out[`SDC_WORD_W-1];
  assign mosi_oe_n_o = ~(mst & en & ~rx_only_i);
  assign miso_o = shift_out[`SDC_WORD_W-1];
  assign miso_oe_n_o = ~(~mst & en & ~rx_only_i & (state == SDC_SHIFT));
endmodule

// file: test/sdc_slave_model.sv
`timescale 1ns/10ps
module sdc_slave_model import sdc_pkg::*; (
  // serial side, mode 0
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  // reply source and capture
  input wire sdc_word_t base_i,
  output sdc_word_t got_o,
  output logic [7:0] frames_o
);
  sdc_word_t sh = 8'h00;
  sdc_word_t out = 8'h00;
  sdc_word_t nxt;
  int n = 0;
  initial got_o = 8'h00;
  initial frames_o = 8'h00;
  // each reply differs, so a dropped or repeated word shows up
  assign nxt = base_i + frames_o;
  // msb must sit on the line before the first rising edge
  assign miso_o = (n == 0) ? nxt[7] : out[7];
  always @(posedge sck_i) begin
    sh = {sh[6:0], mosi_i};
    if (n == 0) out = nxt;
    n = n + 1;
  end
  always @(negedge sck_i) begin
    if (n == 8) begin
      got_o = sh;
      frames_o = frames_o + 8'h01;
      n = 0;
    end else out = {out[6:0], 1'b0};
  end
endmodule

// file: test/sdc_top_checker.sv
`timescale 1ns/10ps
module sdc_top_checker import sdc_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // controls
  input wire logic soft_select_mode_i,
  input wire logic soft_select_level_i,
  input wire logic checksum_enable_i,
  input wire logic checksum_error_clear_i,
  input wire logic tx_dma_enable_i,
  input wire logic rx_dma_enable_i,
  input wire logic tx_empty_irq_enable_i,
  input wire logic rx_full_irq_enable_i,
  input wire logic error_irq_enable_i,
  input wire logic tx_valid_i,
  input wire logic rx_ready_i,
  // observed outputs
  input wire logic tx_ready_o,
  input wire logic rx_valid_o,
  input wire sdc_word_t rx_data_o,
  input wire logic tx_empty_flag_o,
  input wire logic rx_full_flag_o,
  input wire logic config_fault_flag_o,
  input wire logic rx_overrun_flag_o,
  input wire logic checksum_error_flag_o,
  input wire logic format_error_flag_o,
  input wire sdc_word_t tx_checksum_o,
  input wire sdc_word_t rx_checksum_o,
  input wire logic tx_dma_req_o,
  input wire logic rx_dma_req_o,
  input wire logic irq_o,
  input wire logic peripheral_enable_o,
  input wire logic master_select_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // flag relations
  // ----------------------------------------
  a_txdma_req_level: assert property (tx_dma_req_o == (tx_dma_enable_i && tx_empty_flag_o))
    else $error("tx dma request does not follow tx empty");
  a_rxdma_req_level: assert property (rx_dma_req_o == (rx_dma_enable_i && rx_full_flag_o))
    else $error("rx dma request does not follow rx full");
  a_irq_or_gate: assert property (irq_o == ((tx_empty_flag_o && tx_empty_irq_enable_i) ||
    (rx_full_flag_o && rx_full_irq_enable_i) || (error_irq_enable_i && (config_fault_flag_o ||
    rx_overrun_flag_o || checksum_error_flag_o || format_error_flag_o))))
    else $error("interrupt output mismatch");
  a_write_clears_empty: assert property (tx_valid_i && tx_ready_o |=> !tx_empty_flag_o)
    else $error("tx empty still set after write");
  a_rx_full_holds: assert property (rx_full_flag_o && !rx_ready_i |=> rx_full_flag_o)
    else $error("rx full dropped without a read");
  a_overrun_keeps_word: assert property ($rose(rx_overrun_flag_o) |-> $stable(rx_data_o))
    else $error("overrun changed buffered word");
  a_crc_cleared_off: assert property (!checksum_enable_i [*3] |->
    (tx_checksum_o == 8'h00 && rx_checksum_o == 8'h00))
    else $error("checksums not cleared while disabled");
  a_checksum_error_flag_holds: assert property (checksum_error_flag_o && !checksum_error_clear_i |=>
    checksum_error_flag_o)
    else $error("checksum error dropped without clear");
  // ----------------------------------------
  // configuration fault
  // ----------------------------------------
  a_fault_soft_sel: assert property (master_select_o && soft_select_mode_i && !soft_select_level_i
    |-> ##[0:3] config_fault_flag_o)
    else $error("soft select fault not raised");
  a_slave_no_fault: assert property ($rose(config_fault_flag_o) |-> $past(master_select_o))
    else $error("fault raised in slave mode");
  a_fault_drops_bits: assert property ($rose(config_fault_flag_o) |->
    ##[0:2] (!peripheral_enable_o && !master_select_o))
    else $error("fault did not drop enable and master");
  a_fault_locks_bits: assert property (config_fault_flag_o && $past(config_fault_flag_o)
    |-> !$rose(peripheral_enable_o))
    else $error("enable written while fault locked");
  c_overrun: cover property (rx_overrun_flag_o);
  c_crc_error: cover property (checksum_error_flag_o);
  c_fault: cover property (config_fault_flag_o);
  c_format: cover property (format_error_flag_o);
endmodule
bind sdc_top sdc_top_checker sdc_top_checker_i (.*);

// file: test/tb.sv
`timescale 1ns/10ps
module tb import sdc_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ctl_write_i, peripheral_enable_i, master_select_i, soft_select_mode_i, soft_select_level_i, ti_mode_i;
  logic checksum_enable_i, checksum_next_i, tx_dma_enable_i, rx_dma_enable_i, tx_empty_irq_enable_i, rx_only_i;
  logic rx_full_irq_enable_i, error_irq_enable_i, stat_access_i, checksum_error_clear_i, format_error_clear_i;
  logic tx_valid_i, rx_ready_i, sck_i, nss_i, peripheral_enable_o, master_select_o, tx_ready_o, rx_valid_o;
  logic tx_empty_flag_o, rx_full_flag_o, shift_active_flag_o, config_fault_flag_o, rx_overrun_flag_o;
  logic checksum_error_flag_o, format_error_flag_o, tx_dma_req_o, rx_dma_req_o, irq_o, sck_o, mosi_o, miso;
  sdc_word_t poly_i, tx_data_i, rx_data_o, tx_checksum_o, rx_checksum_o, base, got;
  logic [7:0] frames;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  sdc_top sdc_top_i (.clk_i, .rst_i, .ctl_write_i, .peripheral_enable_i, .master_select_i, .peripheral_enable_o,
    .master_select_o, .soft_select_mode_i, .soft_select_level_i, .select_output_enable_i(1'b0), .rx_only_i,
    .tx_only_i(1'b0), .ti_mode_i, .checksum_enable_i, .checksum_next_i, .poly_i, .tx_dma_enable_i, .rx_dma_enable_i,
    .dma_last_i(1'b0), .tx_empty_irq_enable_i, .rx_full_irq_enable_i, .error_irq_enable_i, .stat_access_i,
    .checksum_error_clear_i, .format_error_clear_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o,
    .rx_ready_i, .tx_empty_flag_o, .rx_full_flag_o, .shift_active_flag_o, .config_fault_flag_o, .rx_overrun_flag_o,
    .checksum_error_flag_o, .format_error_flag_o, .tx_checksum_o, .rx_checksum_o, .tx_dma_req_o, .rx_dma_req_o,
    .irq_o, .sck_i, .sck_o, .sck_oe_n_o(), .nss_i, .nss_o(), .nss_oe_n_o(), .mosi_i(1'b0), .mosi_o, .mosi_oe_n_o(),
    .miso_i(miso), .miso_o(), .miso_oe_n_o());
  sdc_slave_model sdc_slave_model_i (.sck_i(sck_o), .mosi_i(mosi_o), .miso_o(miso), .base_i(base), .got_o(got),
    .frames_o(frames));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (exp !== seen) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic sdc_word_t crc8(input sdc_word_t c, input sdc_word_t d);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic ctl(input logic pe, input logic ms);
    @(posedge clk_i);
    ctl_write_i <= 1'b1;
    peripheral_enable_i <= pe;
    master_select_i <= ms;
    @(posedge clk_i);
    ctl_write_i <= 1'b0;
  endtask
  task automatic send(input sdc_word_t w);
    @(posedge clk_i);
    tx_data_i <= w;
    tx_valid_i <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      #1;
      if (tx_ready_o === 1'b1) break;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
    #1;
  endtask
  task automatic wait_frames(input logic [7:0] k);
    logic [7:0] goal;
    goal = frames + k;
    for (int i = 0; i < 2000 && frames != goal; i++) @(posedge clk_i);
    tick(4);
  endtask
  task automatic pop;
    @(posedge clk_i);
    rx_ready_i <= 1'b1;
    @(posedge clk_i);
    rx_ready_i <= 1'b0;
    tick(1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("flags", 8'h80, {tx_empty_flag_o, rx_full_flag_o, shift_active_flag_o, config_fault_flag_o,
      rx_overrun_flag_o, checksum_error_flag_o, format_error_flag_o, peripheral_enable_o});
    @(posedge clk_i);
    tx_empty_irq_enable_i <= 1'b1;
    tick(1);
    chk("irq_tx_empty", 8'h01, {7'h0, irq_o});
    tx_empty_irq_enable_i <= 1'b0;
  endtask
  task automatic t_overrun;
    @(posedge clk_i);
    tx_dma_enable_i <= 1'b1;
    rx_dma_enable_i <= 1'b1;
    rx_full_irq_enable_i <= 1'b1;
    ctl(1'b1, 1'b1);
    send(8'h5a);
    send(8'hc3);
    send(8'h0f);
    chk("tx_ready_dma", 8'h00, {6'h0, tx_ready_o, tx_dma_req_o});
    wait_frames(8'h03);
    chk("dma_irq_ov", 8'h0f, {4'h0, rx_dma_req_o, irq_o, rx_overrun_flag_o, tx_dma_req_o});
    chk("last_sent", 8'h0f, got);
    chk("rx_head", base, rx_data_o);
    pop();
    chk("rx_second", base + 8'h01, rx_data_o);
    @(posedge clk_i);
    stat_access_i <= 1'b1;
    @(posedge clk_i);
    stat_access_i <= 1'b0;
    tick(2);
    chk("overrun", 8'h00, {7'h0, rx_overrun_flag_o});
    pop();
    chk("rx_full", 8'h00, {7'h0, rx_full_flag_o});
  endtask
  task automatic t_checksum;
    sdc_word_t r;
    r = base + frames;
    @(posedge clk_i);
    poly_i <= 8'h07;
    checksum_enable_i <= 1'b1;
    rx_ready_i <= 1'b1;
    send(8'h96);
    @(posedge clk_i);
    checksum_next_i <= 1'b1;
    @(posedge clk_i);
    checksum_next_i <= 1'b0;
    wait_frames(8'h02);
    chk("tx_crc", crc8(8'h00, 8'h96), tx_checksum_o);
    chk("rx_crc", crc8(8'h00, r), rx_checksum_o);
    chk("crc_sent", crc8(8'h00, 8'h96), got);
    chk("crc_err", {7'h0, (r + 8'h01) != crc8(8'h00, r)}, {7'h0, checksum_error_flag_o});
    @(posedge clk_i);
    checksum_error_clear_i <= 1'b1;
    rx_ready_i <= 1'b0;
    @(posedge clk_i);
    checksum_error_clear_i <= 1'b0;
    checksum_enable_i <= 1'b0;
    tick(2);
    chk("crc_err_clr", 8'h00, {7'h0, checksum_error_flag_o});
    chk("stop_flags", 8'h02, {6'h0, tx_empty_flag_o, shift_active_flag_o});
    ctl(1'b0, 1'b1);
  endtask
  task automatic t_rx_only;
    sdc_word_t r, e;
    r = base + frames;
    e = crc8(crc8(8'h00, r), r + 8'h01);
    @(posedge clk_i);
    rx_only_i <= 1'b1;
    checksum_enable_i <= 1'b1;
    rx_ready_i <= 1'b1;
    ctl(1'b1, 1'b1);
    wait_frames(8'h01);
    @(posedge clk_i);
    checksum_next_i <= 1'b1;
    @(posedge clk_i);
    checksum_next_i <= 1'b0;
    wait_frames(8'h01);
    ctl(1'b0, 1'b1);
    wait_frames(8'h01);
    chk("rx_only_err", {7'h0, e != r + 8'h02}, {7'h0, checksum_error_flag_o});
    chk("rx_only_stop", 8'h00, {6'h0, peripheral_enable_o, shift_active_flag_o});
    @(posedge clk_i);
    rx_only_i <= 1'b0;
    checksum_enable_i <= 1'b0;
    checksum_error_clear_i <= 1'b1;
    rx_ready_i <= 1'b0;
    @(posedge clk_i);
    checksum_error_clear_i <= 1'b0;
  endtask
  task automatic t_fault;
    @(posedge clk_i);
    error_irq_enable_i <= 1'b1;
    soft_select_level_i <= 1'b0;
    tick(4);
    chk("fault", 8'h09, {4'h0, config_fault_flag_o, peripheral_enable_o, master_select_o, irq_o});
    soft_select_level_i <= 1'b1;
    ctl(1'b1, 1'b1);
    tick(2);
    chk("locked", 8'h02, {6'h0, config_fault_flag_o, peripheral_enable_o});
    stat_access_i <= 1'b1;
    @(posedge clk_i);
    stat_access_i <= 1'b0;
    soft_select_level_i <= 1'b0;
    ctl(1'b1, 1'b0);
    tick(2);
    chk("fault_clr", 8'h00, {6'h0, config_fault_flag_o, peripheral_enable_o});
    ctl(1'b1, 1'b0);
    tick(4);
    chk("slave_fault", 8'h01, {6'h0, config_fault_flag_o, peripheral_enable_o});
  endtask
  task automatic t_format;
    @(posedge clk_i);
    ti_mode_i <= 1'b1;
    soft_select_mode_i <= 1'b0;
    nss_i <= 1'b0;
    tick(8);
    // three link clock periods of 80 ns, four system clocks a half period
    repeat (6) begin
      repeat (4) @(posedge clk_i);
      sck_i <= ~sck_i;
    end
    @(posedge clk_i);
    nss_i <= 1'b1;
    tick(6);
    chk("format_err", 8'h01, {7'h0, format_error_flag_o});
    format_error_clear_i <= 1'b1;
    @(posedge clk_i);
    format_error_clear_i <= 1'b0;
    tick(2);
    chk("format_clr", 8'h00, {7'h0, format_error_flag_o});
  endtask
  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {ctl_write_i, peripheral_enable_i, master_select_i, ti_mode_i, checksum_enable_i, checksum_next_i} = '0;
    {tx_dma_enable_i, rx_dma_enable_i, tx_empty_irq_enable_i, rx_full_irq_enable_i, error_irq_enable_i} = '0;
    {stat_access_i, checksum_error_clear_i, format_error_clear_i, tx_valid_i, rx_ready_i, sck_i, rx_only_i} = '0;
    {soft_select_mode_i, soft_select_level_i, nss_i} = 3'h7;
    poly_i = 8'h00;
    tx_data_i = 8'h00;
    base = 8'h3c;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    t_reset();
    t_overrun();
    t_checksum();
    t_rx_only();
    t_fault();
    t_format();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule
